// ==== dv/fbd_core_properties.sv ====
// Concurrent checks on the decoder core ports
`timescale 1ns/1ps
`default_nettype none
`include "fbd_consts.svh"
module fbd_core_checker (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [10:0] prog_addr,
  input wire logic [6:0]  file_waddr,
  input wire logic        file_we,
  input wire logic        presc_on_timer,
  input wire logic        presc_clear,
  input wire logic        standby,
  input wire logic        timeout_status_bit,
  input wire logic        powerdown_status_bit,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_bvalid,
  input wire logic        s_bready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Core side
  // ----------------------------------------------------------------
  // Clear pulse leaves in the same cycle as the file write it belongs to
  a_timer_presc: assert property (
    file_we && file_waddr == `FBD_TIMER_ZERO_COUNT_ADDR && $past(presc_on_timer) |-> presc_clear)
    else $error("no presc clear");
  a_presc_cause: assert property (
    presc_clear |-> file_we && file_waddr == `FBD_TIMER_ZERO_COUNT_ADDR) else $error("stray presc clear");
  // Reset must be watched while it is asserted, so no disable here
  a_reset_status: assert property (@(posedge clk) disable iff (1'b0)
    !rstn |=> timeout_status_bit && powerdown_status_bit && !standby) else $error("reset status");
  a_sleep_status: assert property (
    standby && $past(standby) |-> timeout_status_bit && !powerdown_status_bit) else $error("sleep status");
  a_sleep_nofetch: assert property (
    standby && $past(standby) |-> $stable(prog_addr)) else $error("fetch while asleep");
  // ----------------------------------------------------------------
  // Register bus side
  // ----------------------------------------------------------------
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid) else $error("late read");
  a_read_hold: assert property (
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata)) else $error("read data moved");
  a_read_block: assert property (s_rvalid |-> !s_arready) else $error("second read taken");
  a_write_hold: assert property (
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp)) else $error("response moved");
  a_write_done: assert property (s_bvalid && s_bready |=> !s_bvalid) else $error("response stuck");
  c_presc: cover property (presc_clear);
  c_sleep: cover property ($rose(standby));
  c_slverr: cover property (s_bvalid && s_bready && s_bresp == `FBD_RESP_SLVERR);
endmodule
bind fbd_core fbd_core_checker i_fbd_core_checker (
  .clk(clk), .rstn(rstn), .prog_addr(prog_addr), .file_waddr(file_waddr), .file_we(file_we),
  .presc_on_timer(presc_on_timer), .presc_clear(presc_clear), .standby(standby),
  .timeout_status_bit(timeout_status_bit), .powerdown_status_bit(powerdown_status_bit),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid),
  .s_rready(s_rready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready));
`default_nettype wire

// ==== dv/fbd_mem_model.sv ====
// Program memory and file register array facing the decoder core
`timescale 1ns/1ps
`default_nettype none
module fbd_mem_model (
  input  wire logic        clk,
  input  wire logic [10:0] prog_addr,
  output var  logic [13:0] prog_data,
  input  wire logic [6:0]  file_addr,
  output var  logic [7:0]  file_rdata,
  input  wire logic [6:0]  file_waddr,
  input  wire logic [7:0]  file_wdata,
  input  wire logic        file_we
);
  logic [13:0] rom [0:2047];
  logic [7:0]  ram [0:127];
  // Reads answer in the same cycle, as the core expects no wait
  assign prog_data  = rom[prog_addr];
  assign file_rdata = ram[file_addr];
  always @(posedge clk) begin
    if (file_we) begin
      ram[file_waddr] <= file_wdata;
    end
  end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the decoder core with its memory model
`timescale 1ns/1ps
`default_nettype none
`include "fbd_consts.svh"
module testbench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wake_event = 1'b0;
  logic        presc_on_timer = 1'b1;
  logic [23:0] port_pins = 24'h5a_a5c3;
  logic [7:0]  s_awaddr = 8'h00;
  logic [7:0]  s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0000_0000;
  logic [3:0]  s_wstrb = 4'h0;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic        s_arvalid = 1'b0, s_rready = 1'b0;
  logic [10:0] prog_addr;
  logic [13:0] prog_data;
  logic [6:0]  file_addr, file_waddr;
  logic [7:0]  file_rdata, file_wdata;
  logic        file_we, presc_clear, standby, tmo_bit, pdn_bit, wdt_clear;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp;
  logic [31:0] s_rdata;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n_wdt = 0;
  // Row: instr, W in, file in, W out, file out, carry in, flags {Z,DC,C} out, next ran
  logic [63:0] rows [29] = '{
    64'h0220_0503_fe03_1010, 64'h02a0_3333_3300_0710,
    64'h07a0_f808_f800_0710,
    64'h0520_0ff0_00f0_0410, 64'h04a0_0110_0111_1310, 64'h0620_ff0f_f00f_1310,
    64'h09a0_00ff_0000_1710, 64'h0820_7700_0000_0410, 64'h0aa0_12ff_1200_0410,
    64'h0320_0001_0001_0410, 64'h01a0_4499_4400_0410,
    64'h015a_4499_0099_0410,
    64'h00a0_5a00_5a5a_1710,
    64'h0da0_0080_0000_0110, 64'h0c20_0002_8102_1610,
    64'h0e20_00a5_5aa5_1710,
    64'h0ba0_0901_0900_0000, 64'h0f20_0901_0201_0010,
    64'h13a0_00ff_007f_1710, 64'h1420_0000_0001_0010, 64'h1da0_00f7_00f7_0010,
    64'h19a0_00f7_00f7_0000,
    64'h390f_f000_0000_0410, 64'h380c_3000_3c00_1310, 64'h333c_0000_3c00_1710,
    64'h3a5a_5a00_0000_0410,
    64'h3f10_f000_0000_0510, 64'h3c10_0100_0f00_0110,
    64'h0805_0011_c311_0010};

  always #10 clk = ~clk;

  fbd_core i_fbd_core (
    .clk(clk), .rstn(rstn), .prog_addr(prog_addr), .prog_data(prog_data),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .file_we(file_we), .port_pins(port_pins),
    .presc_on_timer(presc_on_timer), .presc_clear(presc_clear), .wdt_clear(wdt_clear),
    .int_enable_set(), .standby(standby), .wake_event(wake_event),
    .timeout_status_bit(tmo_bit), .powerdown_status_bit(pdn_bit),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready));

  fbd_mem_model i_fbd_mem_model (
    .clk(clk), .prog_addr(prog_addr), .prog_data(prog_data), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .file_we(file_we));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Ready of the answer is raised one edge late so the slave must hold it
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er, output logic [31:0] q);
    @(posedge clk);
    if (wr) begin
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= 4'hf;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
    end else begin
      s_araddr <= a;
      s_arvalid <= 1'b1;
    end
    do begin
      @(posedge clk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!(wr ? s_bvalid : s_rvalid));
    if (wr) s_bready <= 1'b1;
    else s_rready <= 1'b1;
    @(posedge clk);
    q = s_rdata;
    chk("resp", {30'h0, er}, {30'h0, wr ? s_bresp : s_rresp});
    s_bready <= 1'b0;
    s_rready <= 1'b0;
  endtask

  // Reset, load six words at address zero, start the core and let it run
  task automatic prog(input logic [13:0] w0, w1, w2, w3, w4, w5, input int n);
    logic [31:0] q;
    rstn <= 1'b0;
    i_fbd_mem_model.rom[0] = w0;
    i_fbd_mem_model.rom[1] = w1;
    i_fbd_mem_model.rom[2] = w2;
    i_fbd_mem_model.rom[3] = w3;
    i_fbd_mem_model.rom[4] = w4;
    i_fbd_mem_model.rom[5] = w5;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    xfer(1'b1, `FBD_OFF_CTRL, 32'h0000_0001, `FBD_RESP_OKAY, q);
    repeat (n) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (wdt_clear) n_wdt++;
    if (cyc == 5000) begin
      mismatches++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [63:0] r;
    logic [31:0] q;
    i_fbd_mem_model.ram[5] = 8'h3c;
    // Carry set up by a literal add, then W loaded, test word, marker bit set, park
    foreach (rows[i]) begin
      r = rows[i];
      i_fbd_mem_model.ram[7'h20] = r[39:32];
      i_fbd_mem_model.ram[7'h21] = 8'h00;
      prog(14'h3000 + 14'(r[12]), 14'h3eff, 14'h3000 + 14'(r[47:40]), r[61:48],
           14'h1421, 14'h2805, 20);
      xfer(1'b0, `FBD_OFF_STATE, 32'h0, `FBD_RESP_OKAY, q);
      chk("w", r[31:24], q[7:0]);
      chk("flags", r[10:8], q[10:8]);
      chk("file", r[23:16], i_fbd_mem_model.ram[7'h20]);
      chk("next", r[4], i_fbd_mem_model.ram[7'h21]);
    end
    // Call into a literal return, then a timer count write
    prog(14'h3011, 14'h2005, 14'h0081, 14'h00a2, 14'h2804, 14'h3766, 20);
    chk("ret", 8'h66, i_fbd_mem_model.ram[7'h22]);
    chk("tmr", 8'h66, i_fbd_mem_model.ram[7'h01]);
    xfer(1'b0, 8'h0c, 32'h0, `FBD_RESP_SLVERR, q);
    chk("unmapped", 32'h0, q);
    xfer(1'b1, 8'h10, 32'h1, `FBD_RESP_SLVERR, q);
    xfer(1'b0, `FBD_OFF_CTRL, 32'h0, `FBD_RESP_OKAY, q);
    chk("ctrl", 32'h1, q);
    // Watchdog clear, standby, then wake and refetch the word that was in flight
    prog(14'h0064, 14'h0063, 14'h0000, 14'h3077, 14'h2804, 14'h0000, 10);
    chk("standby", 1'b1, standby);
    chk("pdn", 1'b0, pdn_bit);
    chk("tmo", 1'b1, tmo_bit);
    chk("wdt", 32'h0000_0002, n_wdt);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    repeat (10) @(posedge clk);
    xfer(1'b0, `FBD_OFF_STATE, 32'h0, `FBD_RESP_OKAY, q);
    chk("wake", 8'h77, q[7:0]);
    test_done();
  end
endmodule
`default_nettype wire

// ==== src/fbd_consts.svh ====
// Constants for the fourteen-bit instruction decoder and executor
`ifndef FBD_CONSTS_SVH
`define FBD_CONSTS_SVH

// ----------------------------------------------------------------
// Instruction classes and codes
// ----------------------------------------------------------------
`define FBD_CLS_BYTE     2'h0
`define FBD_CLS_BIT      2'h1
`define FBD_CLS_CTL      2'h2
`define FBD_CLS_LIT      2'h3
`define FBD_OP_MISC      4'h0
`define FBD_OP_CLR       4'h1
`define FBD_OP_SUB       4'h2
`define FBD_OP_DEC       4'h3
`define FBD_OP_IOR       4'h4
`define FBD_OP_AND       4'h5
`define FBD_OP_XOR       4'h6
`define FBD_OP_ADD       4'h7
`define FBD_OP_MOV       4'h8
`define FBD_OP_COM       4'h9
`define FBD_OP_INC       4'ha
`define FBD_OP_DECSZ     4'hb
`define FBD_OP_RRC       4'hc
`define FBD_OP_RLC       4'hd
`define FBD_OP_SWAP      4'he
`define FBD_OP_INCSZ     4'hf
`define FBD_W_RET        8'h08
`define FBD_W_RETI       8'h09
`define FBD_W_WDTCLR     8'h64
`define FBD_W_STANDBY    8'h63
`define FBD_BIT_CLR      2'h0
`define FBD_BIT_SET      2'h1
`define FBD_BIT_SKC      2'h2
`define FBD_BIT_SKS      2'h3
`define FBD_LIT_LOAD     2'h0
`define FBD_LIT_RET      2'h1
`define FBD_LIT_SUB      3'h6
`define FBD_LIT_ADD      3'h7
`define FBD_LIT_IOR      4'h8
`define FBD_LIT_AND      4'h9
`define FBD_LIT_XOR      4'ha

// ----------------------------------------------------------------
// File addresses, register map, reset values
// ----------------------------------------------------------------
`define FBD_TIMER_ZERO_COUNT_ADDR    7'h01
`define FBD_PORT_BASE    7'h05
`define FBD_OFF_CTRL     8'h00
`define FBD_OFF_STATE    8'h04
`define FBD_OFF_PC       8'h08
`define FBD_RESP_OKAY    2'h0
`define FBD_RESP_SLVERR  2'h2
`define FBD_CTRL_RUN_RST 1'h0
`define FBD_TO_RST       1'h1
`define FBD_PD_RST       1'h1

`endif

// ==== src/fbd_core.sv ====
// Fourteen-bit instruction decoder and executor with an AXI4-Lite control slave
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fbd_consts.svh"

module fbd_core #(
  parameter int STACK_D = 8,
  parameter int NPORT   = 3
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  output var  logic [10:0]          prog_addr,
  input  wire logic [13:0]          prog_data,
  output var  logic [6:0]           file_addr,
  input  wire logic [7:0]           file_rdata,
  output var  logic [6:0]           file_waddr,
  output var  logic [7:0]           file_wdata,
  output var  logic                 file_we,
  input  wire logic [NPORT*8-1:0]   port_pins,
  input  wire logic                 presc_on_timer,
  output var  logic                 presc_clear,
  output var  logic                 wdt_clear,
  output var  logic                 int_enable_set,
  output var  logic                 standby,
  input  wire logic                 wake_event,
  output var  logic                 timeout_status_bit,
  output var  logic                 powerdown_status_bit,
  input  wire logic [7:0]           s_awaddr,
  input  wire logic                 s_awvalid,
  output var  logic                 s_awready,
  input  wire logic [31:0]          s_wdata,
  input  wire logic [3:0]           s_wstrb,
  input  wire logic                 s_wvalid,
  output var  logic                 s_wready,
  output var  logic [1:0]           s_bresp,
  output var  logic                 s_bvalid,
  input  wire logic                 s_bready,
  input  wire logic [7:0]           s_araddr,
  input  wire logic                 s_arvalid,
  output var  logic                 s_arready,
  output var  logic [31:0]          s_rdata,
  output var  logic [1:0]           s_rresp,
  output var  logic                 s_rvalid,
  input  wire logic                 s_rready
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  generate
    if (STACK_D < 2 || (STACK_D & (STACK_D - 1)) != 0) begin : g_bad_stack
      $error("STACK_D must be a power of two, at least 2");
    end
    if (NPORT < 1 || NPORT > 8) begin : g_bad_port
      $error("NPORT must be 1 to 8");
    end
  endgenerate

  localparam int SPW = $clog2(STACK_D);

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  fbd_pkg::fbd_core_state_t state;
  fbd_pkg::fbd_core_state_t next_state;
  logic [13:0]              ir;
  logic                     ir_valid;
  logic [7:0]               w;
  logic                     c_flag;
  logic                     dc_flag;
  logic                     z_flag;
  logic                     run;
  logic [10:0]              stk [STACK_D];
  logic [SPW-1:0]           sp;
  logic [NPORT*8-1:0]       pin_meta;
  logic [NPORT*8-1:0]       pin_sync;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // Only named fields are looked at, so don't-care bits never matter
  // fields only
  wire logic [1:0]  cls     = ir[13:12];
  wire logic [3:0]  op4     = ir[11:8];
  wire logic        dbit    = ir[7];
  wire logic [7:0]  lit     = ir[7:0];
  wire logic [2:0]  bidx    = ir[9:7];
  wire logic [7:0]  bmask   = 8'h01 << bidx;
  wire logic        exec    = ir_valid;

  wire logic [6:0]  port_idx = file_addr - `FBD_PORT_BASE;
  wire logic        is_port  = port_idx < 7'(NPORT);
  // Last cycle's write has not reached the file yet, so forward it
  wire logic        fwd      = file_we && (file_waddr == file_addr);
  wire logic [7:0]  src      = is_port ? pin_sync[port_idx[2:0]*8 +: 8]
                             : fwd     ? file_wdata : file_rdata;
  wire logic [10:0] stk_top  = stk[sp - SPW'(1)];

  function automatic logic [9:0] fbd_add(input logic [7:0] x, input logic [7:0] y,
                                         input logic ci);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    return {n[4], s};
  endfunction

  wire logic [9:0] fw_add = fbd_add(src, w, 1'b0);
  wire logic [9:0] fw_sub = fbd_add(src, ~w, 1'b1);
  wire logic [9:0] kw_add = fbd_add(lit, w, 1'b0);
  wire logic [9:0] kw_sub = fbd_add(lit, ~w, 1'b1);

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------
  logic [7:0]  res;
  logic        wr_w;
  logic        wr_f;
  logic        upd_z;
  logic        upd_c;
  logic        upd_dc;
  logic        new_c;
  logic        new_dc;
  logic        skip;
  logic        branch;
  logic [10:0] tgt;
  logic        push;
  logic        pop;
  logic        do_wdt;
  logic        do_sleep;
  logic        do_reti;

  always_comb begin
    res = 8'h00; wr_w = 1'b0; wr_f = 1'b0; upd_z = 1'b0; upd_c = 1'b0; upd_dc = 1'b0;
    new_c = c_flag; new_dc = dc_flag; skip = 1'b0; branch = 1'b0; tgt = ir[10:0];
    push = 1'b0; pop = 1'b0; do_wdt = 1'b0; do_sleep = 1'b0; do_reti = 1'b0;
    case (cls)
      `FBD_CLS_BYTE: begin
        wr_w = ~dbit;
        wr_f = dbit;
        case (op4)
          `FBD_OP_MISC: begin
            wr_w = 1'b0;
            res  = w;
            if (!dbit) begin
              case (lit)
                `FBD_W_RET: begin pop = 1'b1; branch = 1'b1; tgt = stk_top; end
                `FBD_W_RETI: begin
                  pop = 1'b1; branch = 1'b1; tgt = stk_top; do_reti = 1'b1;
                end
                `FBD_W_WDTCLR: do_wdt = 1'b1;
                `FBD_W_STANDBY: do_sleep = 1'b1;
                default: ;
              endcase
            end
          end
          `FBD_OP_CLR: begin res = 8'h00; upd_z = 1'b1; end
          `FBD_OP_IOR: begin res = w | src; upd_z = 1'b1; end
          `FBD_OP_AND: begin res = w & src; upd_z = 1'b1; end
          `FBD_OP_XOR: begin res = w ^ src; upd_z = 1'b1; end
          `FBD_OP_MOV: begin res = src; upd_z = 1'b1; end
          `FBD_OP_COM: begin res = ~src; upd_z = 1'b1; end
          `FBD_OP_INC: begin res = src + 8'h01; upd_z = 1'b1; end
          `FBD_OP_DEC: begin res = src - 8'h01; upd_z = 1'b1; end
          `FBD_OP_SUB: begin
            res = fw_sub[7:0]; new_c = fw_sub[8]; new_dc = fw_sub[9];
            upd_z = 1'b1; upd_c = 1'b1; upd_dc = 1'b1;
          end
          `FBD_OP_ADD: begin
            res = fw_add[7:0]; new_c = fw_add[8]; new_dc = fw_add[9];
            upd_z = 1'b1; upd_c = 1'b1; upd_dc = 1'b1;
          end
          `FBD_OP_DECSZ: begin res = src - 8'h01; skip = (res == 8'h00); end
          `FBD_OP_INCSZ: begin res = src + 8'h01; skip = (res == 8'h00); end
          `FBD_OP_RRC: begin res = {c_flag, src[7:1]}; new_c = src[0]; upd_c = 1'b1; end
          `FBD_OP_RLC: begin res = {src[6:0], c_flag}; new_c = src[7]; upd_c = 1'b1; end
          `FBD_OP_SWAP: res = {src[3:0], src[7:4]};
          default: ;
        endcase
      end
      `FBD_CLS_BIT: begin
        res = src;
        case (op4[3:2])
          `FBD_BIT_CLR: begin res = src & ~bmask; wr_f = 1'b1; end
          `FBD_BIT_SET: begin res = src | bmask; wr_f = 1'b1; end
          `FBD_BIT_SKC: skip = ~|(src & bmask);
          `FBD_BIT_SKS: skip = |(src & bmask);
          default: ;
        endcase
      end
      `FBD_CLS_CTL: begin
        branch = 1'b1;
        push   = ~ir[11];
      end
      default: begin
        wr_w = 1'b1;
        res  = lit;
        if (op4[3:2] == `FBD_LIT_RET) begin
          pop = 1'b1; branch = 1'b1; tgt = stk_top;
        end else if (op4[3:1] == `FBD_LIT_SUB) begin
          res = kw_sub[7:0]; new_c = kw_sub[8]; new_dc = kw_sub[9];
          upd_z = 1'b1; upd_c = 1'b1; upd_dc = 1'b1;
        end else if (op4[3:1] == `FBD_LIT_ADD) begin
          res = kw_add[7:0]; new_c = kw_add[8]; new_dc = kw_add[9];
          upd_z = 1'b1; upd_c = 1'b1; upd_dc = 1'b1;
        end else if (op4 == `FBD_LIT_IOR) begin
          res = w | lit; upd_z = 1'b1;
        end else if (op4 == `FBD_LIT_AND) begin
          res = w & lit; upd_z = 1'b1;
        end else if (op4 == `FBD_LIT_XOR) begin
          res = w ^ lit; upd_z = 1'b1;
        end else if (op4[3:2] != `FBD_LIT_LOAD) begin
          wr_w = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  wire logic fetch_ok   = (state == fbd_pkg::fbd_running) && !(exec && do_sleep);
  wire logic flush      = exec && (branch || skip);
  wire logic [10:0] next_pc = (exec && branch) ? tgt
                            : ((exec && skip) || fetch_ok) ? prog_addr + 11'h001
                            : prog_addr;

  always_comb begin
    next_state = state;
    case (state)
      fbd_pkg::fbd_halted:   if (run) next_state = fbd_pkg::fbd_running;
      fbd_pkg::fbd_running: begin
        if (exec && do_sleep) next_state = fbd_pkg::fbd_sleeping;
        else if (!run)        next_state = fbd_pkg::fbd_halted;
      end
      fbd_pkg::fbd_sleeping: if (wake_event) next_state = fbd_pkg::fbd_halted;
      default: next_state = fbd_pkg::fbd_halted;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state     <= fbd_pkg::fbd_halted;
      prog_addr <= 11'h000;
      ir        <= 14'h0000;
      ir_valid  <= 1'b0;
      file_addr <= 7'h00;
      standby   <= 1'b0;
    end else begin
      state     <= next_state;
      prog_addr <= next_pc;
      ir        <= prog_data;
      ir_valid  <= fetch_ok && !flush;
      file_addr <= prog_data[6:0];
      standby   <= (next_state == fbd_pkg::fbd_sleeping);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      w <= 8'h00; c_flag <= 1'b0; dc_flag <= 1'b0; z_flag <= 1'b0;
    end else if (exec) begin
      if (wr_w)   w       <= res;
      if (upd_z)  z_flag  <= (res == 8'h00);
      if (upd_c)  c_flag  <= new_c;
      if (upd_dc) dc_flag <= new_dc;
    end
  end

  // Stack wraps silently on overflow, as a circular buffer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sp <= '0;
    end else if (exec && push) begin
      stk[sp] <= prog_addr;
      sp      <= sp + SPW'(1);
    end else if (exec && pop) begin
      sp <= sp - SPW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      file_we <= 1'b0; file_waddr <= 7'h00; file_wdata <= 8'h00; presc_clear <= 1'b0;
      wdt_clear <= 1'b0; int_enable_set <= 1'b0;
      timeout_status_bit <= `FBD_TO_RST; powerdown_status_bit <= `FBD_PD_RST;
    end else begin
      file_we        <= exec && wr_f;
      file_waddr     <= ir[6:0];
      file_wdata     <= res;
      presc_clear    <= exec && wr_f && (ir[6:0] == `FBD_TIMER_ZERO_COUNT_ADDR) && presc_on_timer;
      wdt_clear      <= exec && (do_wdt || do_sleep);
      int_enable_set <= exec && do_reti;
      if (exec && (do_wdt || do_sleep)) begin
        timeout_status_bit   <= 1'b1;
        powerdown_status_bit <= do_wdt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_pin
      always_ff @(posedge clk) begin
        if (!rstn) begin
          pin_meta[g*8 +: 8] <= 8'h00;
          pin_sync[g*8 +: 8] <= 8'h00;
        end else begin
          pin_meta[g*8 +: 8] <= port_pins[g*8 +: 8];
          pin_sync[g*8 +: 8] <= pin_meta[g*8 +: 8];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic        have_aw;
  logic        have_w;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire logic        aw_hs      = s_awvalid && s_awready;
  wire logic        w_hs       = s_wvalid && s_wready;
  wire logic        aw_any     = have_aw || aw_hs;
  wire logic        w_any      = have_w || w_hs;
  wire logic        do_write   = aw_any && w_any && !s_bvalid;
  wire logic [7:0]  wr_addr    = have_aw ? aw_addr : s_awaddr;
  wire logic [31:0] wr_data    = have_w ? w_data : s_wdata;
  wire logic [3:0]  wr_strb    = have_w ? w_strb : s_wstrb;
  wire logic        wr_mapped  = (wr_addr == `FBD_OFF_CTRL) || (wr_addr == `FBD_OFF_STATE)
                              || (wr_addr == `FBD_OFF_PC);
  wire logic        next_bval  = do_write || (s_bvalid && !s_bready);
  wire logic        next_haw   = aw_any && !do_write;
  wire logic        next_hw    = w_any && !do_write;
  wire logic        ar_hs      = s_arvalid && s_arready;
  wire logic        next_rval  = ar_hs || (s_rvalid && !s_rready);
  wire logic [31:0] rd_state   = {19'h0_0000, powerdown_status_bit, timeout_status_bit,
                                  z_flag, dc_flag, c_flag, w};
  wire logic        rd_mapped  = (s_araddr == `FBD_OFF_CTRL) || (s_araddr == `FBD_OFF_STATE)
                              || (s_araddr == `FBD_OFF_PC);
  wire logic [31:0] rd_mux     = (s_araddr == `FBD_OFF_CTRL)  ? {31'h0000_0000, run}
                               : (s_araddr == `FBD_OFF_STATE) ? rd_state
                               : (s_araddr == `FBD_OFF_PC)    ? {21'h00_0000, prog_addr}
                               : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      have_aw <= 1'b0; have_w <= 1'b0; aw_addr <= 8'h00; w_data <= 32'h0000_0000;
      w_strb <= 4'h0; s_awready <= 1'b0; s_wready <= 1'b0; s_bvalid <= 1'b0;
      s_bresp <= `FBD_RESP_OKAY; run <= `FBD_CTRL_RUN_RST;
    end else begin
      have_aw   <= next_haw;
      have_w    <= next_hw;
      if (aw_hs) aw_addr <= s_awaddr;
      if (w_hs) begin
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      s_awready <= !next_haw && !next_bval;
      s_wready  <= !next_hw && !next_bval;
      s_bvalid  <= next_bval;
      if (do_write) begin
        s_bresp <= wr_mapped ? `FBD_RESP_OKAY : `FBD_RESP_SLVERR;
        if (wr_addr == `FBD_OFF_CTRL && wr_strb[0]) run <= wr_data[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_arready <= 1'b0; s_rvalid <= 1'b0; s_rdata <= 32'h0000_0000;
      s_rresp   <= `FBD_RESP_OKAY;
    end else begin
      s_arready <= !next_rval;
      s_rvalid  <= next_rval;
      if (ar_hs) begin
        s_rdata <= rd_mux;
        s_rresp <= rd_mapped ? `FBD_RESP_OKAY : `FBD_RESP_SLVERR;
      end
    end
  end

endmodule

`default_nettype wire

// ==== src/fbd_pkg.sv ====
// Types shared by the decoder core
package fbd_pkg;
  typedef enum logic [1:0] {fbd_halted, fbd_running, fbd_sleeping} fbd_core_state_t;
endpackage
